// ==== hdl/ceh_event_handler.sv ====
//Behaviour
// - eight independent event inputs split into two priority levels
// - high level is events seven to four, low level three to zero
// - each event input is sampled by the system clock before edge detection
// - each level drives its own processor event request line directly
// - flag sets only on sampled rising edge while its enable bit is one
// - a set flag stays pending until software clears it
// - writing one clears a flag, writing zero leaves it unchanged
// - global reset clears all event flags
// - eight-bit read-write enable register, one enables, resets to zero
// - read-only code of highest set event, all ones when none set
// - level status bit one for high, bit zero for low, others zero
// - register offsets are parameters of the block
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
module ceh_event_handler
	import ceh_pkg::*;
#(
	parameter logic [11:0] OFF_FLAGS    = CEH_OFF_FLAGS,
	parameter logic [11:0] OFF_ENABLE   = CEH_OFF_ENABLE,
	parameter logic [11:0] OFF_PRIO     = CEH_OFF_PRIO,
	parameter logic [11:0] OFF_LEVEL    = CEH_OFF_LEVEL,
	parameter logic [11:0] OFF_IRQ_STAT = CEH_OFF_IRQ_STAT,
	parameter logic [11:0] OFF_IRQ_MASK = CEH_OFF_IRQ_MASK
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// event sources
	input  wire logic [7:0]  event_src,
	// processor event requests and interrupt
	output logic             cpu_event_line_a,
	output logic             cpu_event_line_b,
	output logic             irq
);

	// ****************************************
	// helpers
	// ****************************************
	// higher number wins; the scan walks upward so the last hit stays
	function automatic logic [7:0] top_code(input logic [7:0] f);
		logic [7:0] c;
		c = CEH_PRIO_NONE;
		for (int i = 0; i < CEH_NUM_EVT; i++) begin
			if (f[i]) begin
				c = 8'(i);
			end
		end
		return c;
	endfunction

	function automatic logic [1:0] lvl_of(input logic [7:0] f);
		logic [1:0] l;
		l = 2'h0;
		l[CEH_LVL_HIGH] = |f[CEH_NUM_EVT-1:CEH_HIGH_LSB];
		l[CEH_LVL_LOW]  = |f[CEH_HIGH_LSB-1:0];
		return l;
	endfunction

	// ****************************************
	// state
	// ****************************************
	ceh_state_t s_r;
	ceh_state_t s_nxt;
	logic [7:0] rise;
	logic [7:0] clr;
	logic [7:0] flags_new;
	logic [1:0] lvl_new;
	logic [1:0] stat_new;
	logic       wr_data;

	always_comb begin
		s_nxt = s_r;
		// two-stage sampler; only sync2 feeds the edge detector
		s_nxt.sync1 = event_src;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev  = s_r.sync2;
		rise = s_r.sync2 & ~s_r.prev & s_r.enable;
		wr_data = (s_r.st == CEH_ST_DATA) && s_r.ap.sel && s_r.ap.write;
		clr = 8'h00;
		if (wr_data && s_r.ap.addr == OFF_FLAGS) begin
			clr = hwdata[7:0];
		end
		// a rising edge in the clearing cycle survives
		flags_new = (s_r.flags & ~clr) | rise;
		s_nxt.flags = flags_new;
		if (wr_data && s_r.ap.addr == OFF_ENABLE) begin
			s_nxt.enable = hwdata[7:0];
		end
		lvl_new = lvl_of(flags_new);
		s_nxt.prio  = top_code(flags_new);
		s_nxt.level = lvl_new;
		s_nxt.ev_high = lvl_new[CEH_LVL_HIGH];
		s_nxt.ev_low  = lvl_new[CEH_LVL_LOW];
		// level-event interrupt: each level going pending is a sticky event
		stat_new = s_r.irq_stat;
		if (wr_data && s_r.ap.addr == OFF_IRQ_STAT) begin
			stat_new = stat_new & ~hwdata[1:0];
		end
		stat_new = stat_new | (lvl_new & ~s_r.level);
		s_nxt.irq_stat = stat_new;
		if (wr_data && s_r.ap.addr == OFF_IRQ_MASK) begin
			s_nxt.irq_mask = hwdata[1:0];
		end
		s_nxt.irq = |(stat_new & s_nxt.irq_mask);
		// bus: one address phase, one zero-wait data phase
		s_nxt.ap.sel   = hsel && hready && htrans == CEH_HTRANS_NSQ;
		s_nxt.ap.write = hwrite;
		s_nxt.ap.addr  = haddr[11:0];
		s_nxt.st = s_nxt.ap.sel ? CEH_ST_DATA : CEH_ST_IDLE;
		s_nxt.rdata = 32'h0;
		if (s_nxt.ap.sel && !hwrite) begin
			case (haddr[11:0])
				OFF_FLAGS:    s_nxt.rdata = {24'h0, flags_new};
				OFF_ENABLE:   s_nxt.rdata = {24'h0, s_nxt.enable};
				OFF_PRIO:     s_nxt.rdata = {24'h0, s_nxt.prio};
				OFF_LEVEL:    s_nxt.rdata = {30'h0, lvl_new};
				OFF_IRQ_STAT: s_nxt.rdata = {30'h0, stat_new};
				OFF_IRQ_MASK: s_nxt.rdata = {30'h0, s_nxt.irq_mask};
				default:      s_nxt.rdata = 32'h0;
			endcase
		end
		if (!reset_n) begin
			s_nxt = '0;
			s_nxt.st   = CEH_ST_IDLE;
			s_nxt.prio = CEH_PRIO_NONE;
			s_nxt.flags  = CEH_RST_BYTE;
			s_nxt.enable = CEH_RST_BYTE;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hrdata           = s_r.rdata;
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign cpu_event_line_a = s_r.ev_high;
	assign cpu_event_line_b = s_r.ev_low;
	assign irq              = s_r.irq;

	// ****************************************
	// checks
	// ****************************************
	a_flag_rise: assert property (@(posedge clk) disable iff (!reset_n)
		(s_r.sync2 & ~s_r.prev & s_r.enable) != 8'h00 |=> (s_r.flags != 8'h00))
		else $error("enabled rising edge did not set a flag");
	a_flag_gate: assert property (@(posedge clk) disable iff (!reset_n)
		((s_r.flags & ~$past(s_r.flags)) & ~$past(s_r.enable)) == 8'h00)
		else $error("flag set while its source disabled");
	a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr_data && s_r.ap.addr == OFF_FLAGS) |=> (($past(s_r.flags) & ~s_r.flags) == 8'h00))
		else $error("flag dropped without a clear");
	a_clear_one: assert property (@(posedge clk) disable iff (!reset_n)
		wr_data && s_r.ap.addr == OFF_FLAGS && rise == 8'h00
		|=> s_r.flags == ($past(s_r.flags) & ~$past(hwdata[7:0])))
		else $error("write-one clear wrong");
	a_prio_none: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.flags == 8'h00 |-> s_r.prio == CEH_PRIO_NONE)
		else $error("code not all ones with no flag");
	a_prio_top: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.flags[7] |-> s_r.prio == 8'h07)
		else $error("event seven not highest");
	a_level_map: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.level == {|s_r.flags[7:4], |s_r.flags[3:0]})
		else $error("level status mismatch");
	a_line_map: assert property (@(posedge clk) disable iff (!reset_n)
		cpu_event_line_a == |s_r.flags[7:4] && cpu_event_line_b == |s_r.flags[3:0])
		else $error("event line mismatch");
	a_reset_clr: assert property (@(posedge clk)
		!reset_n |=> s_r.flags == 8'h00 && s_r.enable == 8'h00 && s_r.prio == CEH_PRIO_NONE)
		else $error("reset did not clear");

	// ****************************************
	// sampler and flag checks
	// ****************************************
	// the first edge after reset compares against reset values, so skip it
	a_sync_first: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n)
		|-> s_r.sync1 == $past(event_src))
		else $error("first sampler stage wrong");
	a_sync_second: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n)
		|-> s_r.sync2 == $past(s_r.sync1))
		else $error("second sampler stage wrong");
	a_prev_stage: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n)
		|-> s_r.prev == $past(s_r.sync2))
		else $error("edge detector history wrong");
	a_no_edge: assert property (@(posedge clk) disable iff (!reset_n)
		rise == 8'h00
		|=> (s_r.flags & ~$past(s_r.flags)) == 8'h00)
		else $error("flag set without a rising edge");

	// ****************************************
	// register checks
	// ****************************************
	a_enable_write: assert property (@(posedge clk) disable iff (!reset_n)
		wr_data && s_r.ap.addr == OFF_ENABLE
		|=> s_r.enable == $past(hwdata[7:0]))
		else $error("enable write did not land");
	a_enable_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr_data && s_r.ap.addr == OFF_ENABLE)
		|=> s_r.enable == $past(s_r.enable))
		else $error("enable changed without a write");
	a_prio_range: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.prio == CEH_PRIO_NONE || s_r.prio < 8'h08)
		else $error("event code out of range");
	a_prio_max: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.prio != CEH_PRIO_NONE
		|-> (s_r.flags >> s_r.prio[2:0]) == 8'h01)
		else $error("event code not the highest set flag");
	a_rd_level: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.st == CEH_ST_DATA && s_r.ap.sel && !s_r.ap.write && s_r.ap.addr == OFF_LEVEL
		|-> hrdata[31:2] == 30'h0)
		else $error("level status upper bits not zero");

	// ****************************************
	// bus and interrupt checks
	// ****************************************
	a_bus_okay: assert property (@(posedge clk) disable iff (!reset_n)
		hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_bus_take: assert property (@(posedge clk) disable iff (!reset_n)
		hsel && hready && htrans == CEH_HTRANS_NSQ
		|=> s_r.st == CEH_ST_DATA)
		else $error("request not taken");
	a_rd_idle: assert property (@(posedge clk) disable iff (!reset_n)
		s_r.st == CEH_ST_IDLE
		|-> hrdata == 32'h0)
		else $error("read data outside a data phase");
	a_irq_out: assert property (@(posedge clk) disable iff (!reset_n)
		irq == |(s_r.irq_stat & s_r.irq_mask))
		else $error("interrupt output mismatch");
	a_irq_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr_data && s_r.ap.addr == OFF_IRQ_STAT)
		|=> ($past(s_r.irq_stat) & ~s_r.irq_stat) == 2'h0)
		else $error("interrupt status dropped without a clear");
	a_irq_rise: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n)
		|-> (s_r.level & ~$past(s_r.level) & ~s_r.irq_stat) == 2'h0)
		else $error("level going pending did not set status");

	c_high_evt: cover property (@(posedge clk) disable iff (!reset_n) cpu_event_line_a);
	c_both_lvl: cover property (@(posedge clk) disable iff (!reset_n)
		cpu_event_line_a && cpu_event_line_b);
	c_clear_evt: cover property (@(posedge clk) disable iff (!reset_n)
		s_r.flags != 8'h00 ##1 s_r.flags == 8'h00);
	c_irq: cover property (@(posedge clk) disable iff (!reset_n) irq);

endmodule

// ==== hdl/ceh_pkg.sv ====
package ceh_pkg;

	// ****************************************
	// register map (offsets overridable in the top)
	// ****************************************
	localparam logic [11:0] CEH_OFF_FLAGS    = 12'h000;
	localparam logic [11:0] CEH_OFF_ENABLE   = 12'h004;
	localparam logic [11:0] CEH_OFF_PRIO     = 12'h008;
	localparam logic [11:0] CEH_OFF_LEVEL    = 12'h00c;
	localparam logic [11:0] CEH_OFF_IRQ_STAT = 12'h010;
	localparam logic [11:0] CEH_OFF_IRQ_MASK = 12'h014;

	localparam int          CEH_NUM_EVT  = 8;
	localparam int          CEH_HIGH_LSB = 4;
	localparam int          CEH_LVL_HIGH = 1;
	localparam int          CEH_LVL_LOW  = 0;
	localparam int          CEH_IRQ_HIGH = 1;
	localparam int          CEH_IRQ_LOW  = 0;
	localparam logic [7:0]  CEH_PRIO_NONE  = 8'hff;
	localparam logic [7:0]  CEH_RST_BYTE   = 8'h00;
	localparam logic [1:0]  CEH_HTRANS_NSQ = 2'h2;
	localparam logic [2:0]  CEH_HSIZE_WORD = 3'h2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		CEH_ST_IDLE = 2'b01,
		CEH_ST_DATA = 2'b10
	} ceh_bus_st_t;

	typedef struct packed {
		logic       sel;
		logic       write;
		logic [11:0] addr;
	} ceh_aphase_t;

	typedef struct packed {
		ceh_bus_st_t st;
		ceh_aphase_t ap;
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic [7:0]  prev;
		logic [7:0]  flags;
		logic [7:0]  enable;
		logic [7:0]  prio;
		logic [1:0]  level;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic        irq;
		logic        ev_high;
		logic        ev_low;
		logic [31:0] rdata;
	} ceh_state_t;

endpackage

// ==== testbench/ceh_src_model.sv ====
// ****************************************
// event source model
// ****************************************
// peripherals change their event levels only right after a clock edge
module ceh_src_model (
	// clock
	input  wire logic       clk,
	// requested levels
	input  wire logic [7:0] want,
	// event lines
	output logic      [7:0] event_src
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk) begin
		event_src <= want;
	end
endmodule

// ==== testbench/tb.sv ====
module tb
	import ceh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk     = 1'b0;
	logic        reset_n = 1'b0;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic [7:0]  want    = 8'h00;
	logic [7:0]  event_src;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        line_a;
	logic        line_b;
	logic        irq;
	logic [31:0] rd;
	logic [7:0]  b;
	logic        ok;
	int          n_errors = 0;
	int          n_tests  = 0;
	always #10 clk = ~clk;
	ceh_event_handler i_dut (
		.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(CEH_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .event_src(event_src),
		.cpu_event_line_a(line_a), .cpu_event_line_b(line_b), .irq(irq)
	);
	ceh_src_model i_src (.clk(clk), .want(want), .event_src(event_src));
	// ****************************************
	// tasks
	// ****************************************
	task stop_test;
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// outputs are taken half a cycle early, where they are settled for the coming edge
	task wait_rdy;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			ok = (hreadyout === 1'b1);
			rd = hrdata;
			@(posedge clk);
			if (ok)
				return;
		end
		n_errors++;
		$display("wrong value at %0t: bus never ready", $time);
		stop_test;
	endtask
	// called just after a rising edge; returns at the edge that ends the data phase
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= CEH_HTRANS_NSQ;
		haddr  <= {20'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask
	task rchk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, {24'h0, e});
	endtask
	// source model, two sync stages and flag register need four edges; six leaves margin
	task ev(input logic [7:0] v);
		want <= v;
		repeat (6) @(posedge clk);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rchk(CEH_OFF_FLAGS, 8'h00);
		rchk(CEH_OFF_ENABLE, CEH_RST_BYTE);
		rchk(CEH_OFF_PRIO, CEH_PRIO_NONE);
		rchk(CEH_OFF_LEVEL, 8'h00);
		bus(1'b1, CEH_OFF_ENABLE, 32'ha5);
		rchk(CEH_OFF_ENABLE, 8'ha5);
		rchk(12'h100, 8'h00);
		bus(1'b1, CEH_OFF_ENABLE, 32'h0f);
		ev(8'hf0);
		rchk(CEH_OFF_FLAGS, 8'h00);
		ev(8'h00);
		bus(1'b1, CEH_OFF_ENABLE, 32'hff);
		bus(1'b1, CEH_OFF_IRQ_MASK, 32'h3);
		rchk(CEH_OFF_IRQ_MASK, 8'h03);
		for (int i = 0; i < CEH_NUM_EVT; i++) begin
			b = 8'h01 << i;
			ev(b);
			rchk(CEH_OFF_FLAGS, b);
			rchk(CEH_OFF_PRIO, 8'(i));
			rchk(CEH_OFF_LEVEL, (i >= CEH_HIGH_LSB) ? 8'h02 : 8'h01);
			rchk(CEH_OFF_IRQ_STAT, (i >= CEH_HIGH_LSB) ? 8'h02 : 8'h01);
			chk({irq, line_a, line_b}, {1'b1, i >= CEH_HIGH_LSB, i < CEH_HIGH_LSB});
			bus(1'b1, CEH_OFF_FLAGS, {24'h0, b});
			bus(1'b1, CEH_OFF_IRQ_STAT, 32'h3);
			ev(8'h00);
			rchk(CEH_OFF_FLAGS, 8'h00);
			chk({irq, line_a, line_b}, 3'b000);
		end
		ev(8'h22);
		rchk(CEH_OFF_PRIO, 8'h05);
		rchk(CEH_OFF_LEVEL, 8'h03);
		ev(8'h00);
		rchk(CEH_OFF_FLAGS, 8'h22);
		bus(1'b1, CEH_OFF_FLAGS, 32'h00);
		rchk(CEH_OFF_FLAGS, 8'h22);
		bus(1'b1, CEH_OFF_FLAGS, 32'h20);
		rchk(CEH_OFF_FLAGS, 8'h02);
		rchk(CEH_OFF_PRIO, 8'h01);
		bus(1'b1, CEH_OFF_IRQ_MASK, 32'h0);
		@(posedge clk);
		chk({irq, line_a, line_b}, 3'b001);
		// reset in mid-run must drop the pending flag and the enables
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rchk(CEH_OFF_FLAGS, 8'h00);
		rchk(CEH_OFF_ENABLE, 8'h00);
		rchk(CEH_OFF_PRIO, CEH_PRIO_NONE);
		stop_test;
	end
endmodule
